// ### src/mfri_core.sv
// Fault, reverse power and pulse output logic with APB registers
`timescale 1ns/1ps
module mfri_core
   import mfri_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire mfri_meas_t        meas,
   input  wire logic              meas_valid,
   input  wire logic [MIS_W-1:0]  missing_neutral_cal_in,
   input  wire logic              supply_ok_pin,
   input  wire logic              gain_select,
   input  wire logic              freq_select_hi,
   input  wire logic              freq_select_lo,
   input  wire logic              cal_freq_select,
   output logic                   fault_flag,
   output logic                   reverse_power_flag,
   output logic                   calibration_pulse_out,
   output logic                   low_freq_out_a,
   output logic                   low_freq_out_b,
   output logic                   irq
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_N-1:0] pins_in;    // Raw strap and supply pins
   logic [PIN_N-1:0] s1_reg;     // First stage, read by s2 only
   logic [PIN_N-1:0] s2_reg;
   logic [PIN_N-1:0] s3_reg;
   logic [PIN_N-1:0] pin_reg;    // Accepted level
   logic [PIN_N-1:0] pin_next;
   mfri_strap_t      strap;      // Accepted straps
   logic             supply_ok;

   assign pins_in = {supply_ok_pin, gain_select, freq_select_hi,
                     freq_select_lo, cal_freq_select};

   // A level is accepted once stages two and three agree
   generate
      for (genvar i = 0; i < PIN_N; i++) begin : g_pin
         assign pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i]
                                                        : pin_reg[i];
      end
   endgenerate

   // Shift chain and accepted level register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         pin_reg <= '0;
      end else begin
         s1_reg  <= pins_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         pin_reg <= pin_next;
      end
   end

   assign strap     = pin_reg[PIN_GAIN:PIN_SCF];
   assign supply_ok = pin_reg[PIN_SUP];

   // ---------------------------------------------------------------
   // Detection and energy increment
   // ---------------------------------------------------------------
   logic [CUR_W-1:0]       diff;      // Absolute current difference
   logic [CUR_W-1:0]       larger;    // Larger of the two currents
   logic                   mismatch;
   logic                   missing;
   logic                   chan_b;    // Input B is billed
   logic signed [PWR_W-1:0] pwr_sel;
   logic                   neg;       // Negative active power
   logic [PWR_W:0]         pwr_mag;
   logic [PWR_W-1:0]       amp_hr;    // Missing neutral quantity
   logic [PWR_W-1:0]       base;
   logic [INC_W-1:0]       incr;
   logic [ACC_W-1:0]       lf_thr;
   logic [ACC_W-1:0]       cf_thr;

   // Pure function of the current sample
   always_comb begin
      if (meas.current_in_a > meas.current_in_b) begin
         diff   = meas.current_in_a - meas.current_in_b;
         larger = meas.current_in_a;
      end else begin
         diff   = meas.current_in_b - meas.current_in_a;
         larger = meas.current_in_b;
      end
      mismatch = diff > (larger >> MISMATCH_SHIFT);
      missing  = meas.volt_mag < VOLT_MIN;
      chan_b   = meas.current_in_b > meas.current_in_a;
      pwr_sel  = chan_b ? meas.pwr_b : meas.pwr_a;
      // Without voltage there is no sign, only a current quantity
      neg      = !missing && pwr_sel[PWR_W-1];
      pwr_mag  = pwr_sel[PWR_W-1] ? -{pwr_sel[PWR_W-1], pwr_sel}
                                  : {1'b0, pwr_sel};
      // Both operands at full width so the product is not cut early
      amp_hr   = {8'h00, larger}
                 * {16'h0000, missing_neutral_cal_in};
      base     = missing ? amp_hr : pwr_mag[PWR_W-1:0];
      // Gain 16 is a 4-bit left shift of the increment
      incr     = strap.gain_select ? {base, GAIN16_PAD}
                                   : {GAIN16_PAD, base};
      case ({strap.freq_select_hi, strap.freq_select_lo})
         2'b00:   lf_thr = LF_THR_0;
         2'b01:   lf_thr = LF_THR_1;
         2'b10:   lf_thr = LF_THR_2;
         2'b11:   lf_thr = LF_THR_3;
         default: lf_thr = LF_THR_0;
      endcase
      cf_thr   = strap.cal_freq_select ? lf_thr >> CF_SHIFT_HI
                                       : lf_thr >> CF_SHIFT_LO;
   end

   // ---------------------------------------------------------------
   // Calibration pulse generator
   // ---------------------------------------------------------------
   logic active_reg;      // Supply good and enabled
   logic cf_fire;         // One-cycle strobe, pulse starts next cycle

   mfri_pulse_gen u_cf (
      .mclk      (mclk),
      .nrst      (nrst),
      .en        (active_reg),
      .sample    (meas_valid),
      .incr      (incr),
      .thr       (cf_thr),
      .fire      (cf_fire),
      .pulse_out (calibration_pulse_out)
   );

   // ---------------------------------------------------------------
   // Indicators and low-rate outputs
   // ---------------------------------------------------------------
   logic       ctrl_en_reg;   // Software enable
   logic       active_next;
   logic       fault_reg;
   logic       fault_next;
   logic       reverse_power_flag_reg;
   logic       reverse_power_flag_next;
   logic [7:0] lf_div_reg;    // CF pulses since last low-rate pulse
   logic [7:0] lf_div_next;
   logic [8:0] lf_cnt_reg;    // Remaining high cycles
   logic [8:0] lf_cnt_next;
   logic       lf_ph_reg;     // Next low-rate pulse goes on B if set
   logic       lf_ph_next;
   logic       lfa_reg;
   logic       lfa_next;
   logic       lfb_reg;
   logic       lfb_next;
   logic       lf_fire;
   logic [7:0] lf_term;

   always_comb begin
      active_next = supply_ok && ctrl_en_reg;
      fault_next  = mismatch || missing;
      // Sign is sampled only as a CF pulse starts
      reverse_power_flag_next   = cf_fire ? neg : reverse_power_flag_reg;
      lf_term     = strap.cal_freq_select ? CF_PER_LF_HI : CF_PER_LF_LO;
      lf_fire     = 1'b0;
      lf_div_next = lf_div_reg;
      lf_cnt_next = lf_cnt_reg;
      lf_ph_next  = lf_ph_reg;
      if (!active_reg) begin
         lf_div_next = 8'h00;
         lf_cnt_next = 9'h000;
         lf_ph_next  = 1'b0;
      end else begin
         if (cf_fire) begin
            if (lf_div_reg >= lf_term) begin
               lf_div_next = 8'h00;
               lf_fire     = 1'b1;
            end else begin
               lf_div_next = lf_div_reg + 8'h01;
            end
         end
         // A pulse due while one is still high is skipped
         if (lf_fire && lf_cnt_reg == 9'h000) begin
            lf_cnt_next = LF_PULSE_LD;
            lf_ph_next  = !lf_ph_reg;
         end else if (lf_cnt_reg != 9'h000) begin
            lf_cnt_next = lf_cnt_reg - 9'h001;
         end
      end
      // Alternate outputs suit a two-phase stepper
      lfa_next = (lf_cnt_next != 9'h000) && lf_ph_next;
      lfb_next = (lf_cnt_next != 9'h000) && !lf_ph_next;
   end

   // All indicator outputs come straight from flip-flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         active_reg <= 1'b0;
         fault_reg  <= 1'b0;
         reverse_power_flag_reg   <= 1'b0;
         lf_div_reg <= 8'h00;
         lf_cnt_reg <= 9'h000;
         lf_ph_reg  <= 1'b0;
         lfa_reg    <= 1'b0;
         lfb_reg    <= 1'b0;
      end else begin
         active_reg <= active_next;
         fault_reg  <= fault_next;
         reverse_power_flag_reg   <= reverse_power_flag_next;
         lf_div_reg <= lf_div_next;
         lf_cnt_reg <= lf_cnt_next;
         lf_ph_reg  <= lf_ph_next;
         lfa_reg    <= lfa_next;
         lfb_reg    <= lfb_next;
      end
   end

   assign fault_flag         = fault_reg;
   assign reverse_power_flag = reverse_power_flag_reg;
   assign low_freq_out_a     = lfa_reg;
   assign low_freq_out_b     = lfb_reg;

   // ---------------------------------------------------------------
   // APB slave and interrupts
   // ---------------------------------------------------------------
   logic [IRQ_W-1:0]  irq_stat_reg;
   logic [IRQ_W-1:0]  irq_stat_next;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic [IRQ_W-1:0]  irq_mask_next;
   logic              ctrl_en_next;
   logic [DATA_W-1:0] cf_count_reg;   // CF pulses issued
   logic [DATA_W-1:0] cf_count_next;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic              irq_reg;
   logic              irq_next;
   logic [IRQ_W-1:0]  ev;             // Events this cycle
   logic [IRQ_W-1:0]  w1c;            // Bits cleared by software
   logic [DATA_W-1:0] rd_mux;
   logic              mapped;
   logic              wr;

   always_comb begin
      wr     = psel && penable && pwrite;
      mapped = 1'b1;
      rd_mux = '0;
      case (paddr)
         REG_CTRL:     rd_mux[CTRL_EN_BIT] = ctrl_en_reg;
         REG_STATUS: begin
            rd_mux[ST_FAULT] = fault_reg;
            rd_mux[ST_REVERSE_POWER_FLAG]  = reverse_power_flag_reg;
            rd_mux[ST_MISM]  = mismatch;
            rd_mux[ST_MISS]  = missing;
            rd_mux[ST_CHANB] = chan_b;
            rd_mux[ST_ACT]   = active_reg;
            rd_mux[ST_SUP]   = supply_ok;
            rd_mux[ST_STRAP +: 4] = strap;
         end
         REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
         REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
         REG_CF_COUNT: rd_mux = cf_count_reg;
         default:      mapped = 1'b0;
      endcase
      // Read data is captured in the setup cycle, zero wait states
      prdata_next = (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
      ev = '0;
      ev[IRQ_FAULT_SET] = fault_next && !fault_reg;
      ev[IRQ_FAULT_CLR] = !fault_next && fault_reg;
      ev[IRQ_REVERSE_POWER_FLAG_CHG]  = reverse_power_flag_next != reverse_power_flag_reg;
      ev[IRQ_SUP_LOSS]  = !pin_next[PIN_SUP] && pin_reg[PIN_SUP];
      ev[IRQ_CF]        = cf_fire;
      w1c = (wr && paddr == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
      // Set wins over a clear in the same cycle
      irq_stat_next = (irq_stat_reg & ~w1c) | ev;
      irq_mask_next = (wr && paddr == REG_IRQ_MASK) ? pwdata[IRQ_W-1:0]
                                                    : irq_mask_reg;
      ctrl_en_next  = (wr && paddr == REG_CTRL) ? pwdata[CTRL_EN_BIT]
                                                : ctrl_en_reg;
      cf_count_next = cf_fire ? cf_count_reg + 32'h0000_0001
                              : cf_count_reg;
      irq_next      = |(irq_stat_next & irq_mask_next);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= IRQ_MASK_RST;
         ctrl_en_reg  <= CTRL_EN_RST;
         cf_count_reg <= '0;
         prdata_reg   <= '0;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         ctrl_en_reg  <= ctrl_en_next;
         cf_count_reg <= cf_count_next;
         prdata_reg   <= prdata_next;
         irq_reg      <= irq_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign irq     = irq_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence cf_start;
      cf_fire ##1 $rose(calibration_pulse_out);
   endsequence

   AST_FAULT_MISMATCH: assert property (
      mismatch |=> fault_flag)
      else $error("mismatch did not raise fault");
   AST_FAULT_MISSING: assert property (
      missing |=> fault_flag)
      else $error("missing neutral did not raise fault");
   AST_FAULT_CLEAR: assert property (
      (!mismatch && !missing) |=> !fault_flag)
      else $error("fault not cleared");
   AST_REVERSE_POWER_FLAG_SET: assert property (
      (cf_fire && neg) |-> ##1 (reverse_power_flag
                                && calibration_pulse_out))
      else $error("reverse flag not set with CF");
   AST_REVERSE_POWER_FLAG_CLEAR: assert property (
      (cf_fire && !neg) |=> !reverse_power_flag)
      else $error("reverse flag not cleared");
   AST_REVERSE_POWER_FLAG_WITH_CF: assert property (
      $changed(reverse_power_flag) |-> $past(cf_fire)
                                       && $rose(calibration_pulse_out))
      else $error("reverse flag moved without CF");
   AST_INACTIVE_QUIET: assert property (
      !active_reg |=> (!calibration_pulse_out && !low_freq_out_a
                       && !low_freq_out_b))
      else $error("pulse output while inactive");
   AST_LF_EXCL: assert property (
      !(low_freq_out_a && low_freq_out_b))
      else $error("both low-rate outputs high");
   AST_CF_FOLLOWS: assert property (
      (cf_fire && active_next) |-> cf_start)
      else $error("CF pulse did not start");
   AST_IRQ_LEVEL: assert property (
      (|(irq_stat_reg & irq_mask_reg)) |-> irq)
      else $error("interrupt not raised");

endmodule : mfri_core

// ### src/mfri_pkg.sv
// Package: constants and carrier types of the fault and reverse-power block
//
// How it works
// - Fault high when currents differ over 6.25%
// - Fault high when voltage channel is missing
// - Fault returns low once both conditions clear
// - Reverse flag high on negative active power
// - Reverse flag unlatched, clears on positive power
// - Reverse flag changes only with a CF pulse
// - Static gain strap selects gain 1 or 16
// - Two frequency straps pick one of four rates
// - Calibration strap picks the CF output rate
// - CF pulses, active high, track instantaneous power
// - Two low-rate outputs track average power
// - Missing neutral scales rates by calibration level
// - Only the larger current input is billed
// - Supply low: no accumulation, pulse outputs off
package mfri_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int CUR_W  = 16;           // Current magnitude sample
   localparam int PWR_W  = 24;           // Signed active power sample
   localparam int MIS_W  = 8;            // Missing neutral level
   localparam int INC_W  = 28;           // Energy increment
   localparam int ACC_W  = 36;           // Energy accumulator
   localparam int ADDR_W = 8;            // APB address
   localparam int DATA_W = 32;           // APB data
   localparam int IRQ_W  = 5;            // Interrupt sources
   localparam int PIN_N  = 5;            // Synchronised pins

   // ---------------------------------------------------------------
   // Detection and scaling
   // ---------------------------------------------------------------
   localparam int              MISMATCH_SHIFT = 4;  // 1/16 is 6.25 %
   localparam logic [CUR_W-1:0] VOLT_MIN      = 16'h0080;
   localparam logic [3:0]      GAIN16_PAD     = 4'h0; // x16 = 4 bits

   // Energy per low-rate pulse, one per frequency select code
   localparam logic [ACC_W-1:0] LF_THR_0 = 36'h0_4000_0000;
   localparam logic [ACC_W-1:0] LF_THR_1 = 36'h0_2000_0000;
   localparam logic [ACC_W-1:0] LF_THR_2 = 36'h0_1000_0000;
   localparam logic [ACC_W-1:0] LF_THR_3 = 36'h0_0800_0000;
   // CF runs 64x or 128x faster than the low-rate outputs
   localparam int              CF_SHIFT_LO  = 6;
   localparam int              CF_SHIFT_HI  = 7;
   localparam logic [7:0]      CF_PER_LF_LO = 8'h3F;  // Terminal count
   localparam logic [7:0]      CF_PER_LF_HI = 8'h7F;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;      // mclk at 200 MHz
   localparam int CF_PULSE_NS   = 40;
   localparam int LF_PULSE_NS   = 1280;
   localparam int CF_PULSE_CYC  =
      (CF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LF_PULSE_CYC  =
      (LF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CF_PULSE_LD = 4'(CF_PULSE_CYC);
   localparam logic [8:0] LF_PULSE_LD = 9'(LF_PULSE_CYC);

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_CF_COUNT = 8'h10;
   localparam int                CTRL_EN_BIT  = 0;
   localparam logic              CTRL_EN_RST  = 1'b1;
   localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 5'h00;
   // Status bit positions
   localparam int ST_FAULT = 0;
   localparam int ST_REVERSE_POWER_FLAG  = 1;
   localparam int ST_MISM  = 2;
   localparam int ST_MISS  = 3;
   localparam int ST_CHANB = 4;
   localparam int ST_ACT   = 5;
   localparam int ST_SUP   = 6;
   localparam int ST_STRAP = 8;          // Four strap bits from here
   // Interrupt bit positions
   localparam int IRQ_FAULT_SET = 0;
   localparam int IRQ_FAULT_CLR = 1;
   localparam int IRQ_REVERSE_POWER_FLAG_CHG  = 2;
   localparam int IRQ_SUP_LOSS  = 3;
   localparam int IRQ_CF        = 4;
   // Pin vector positions
   localparam int PIN_SUP  = 4;
   localparam int PIN_GAIN = 3;
   localparam int PIN_FHI  = 2;
   localparam int PIN_FLO  = 1;
   localparam int PIN_SCF  = 0;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        [CUR_W-1:0] current_in_a;  // Current magnitude A
      logic        [CUR_W-1:0] current_in_b;  // Current magnitude B
      logic        [CUR_W-1:0] volt_mag;      // Voltage magnitude
      logic signed [PWR_W-1:0] pwr_a;         // Power using input A
      logic signed [PWR_W-1:0] pwr_b;         // Power using input B
   } mfri_meas_t;

   typedef struct packed {
      logic gain_select;
      logic freq_select_hi;
      logic freq_select_lo;
      logic cal_freq_select;
   } mfri_strap_t;

endpackage : mfri_pkg

// ### src/mfri_pulse_gen.sv
// Energy accumulator that emits fixed-width calibration pulses
`timescale 1ns/1ps
module mfri_pulse_gen
   import mfri_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             en,
   input  wire logic             sample,
   input  wire logic [INC_W-1:0] incr,
   input  wire logic [ACC_W-1:0] thr,
   output logic                  fire,
   output logic                  pulse_out
);

   logic [ACC_W-1:0] acc_reg;     // Accumulated energy
   logic [ACC_W-1:0] acc_next;
   logic [ACC_W-1:0] sum;         // Energy including this sample
   logic [3:0]       cnt_reg;     // Remaining high cycles
   logic [3:0]       cnt_next;
   logic             out_reg;     // Output level
   logic             out_next;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // A pulse that is due while the previous is still high waits; the
   // excess stays in the accumulator so no energy is dropped.
   always_comb begin
      sum = sample ? acc_reg + {{(ACC_W-INC_W){1'b0}}, incr} : acc_reg;
      fire = en && (cnt_reg == 4'h0) && (thr != '0) && (sum >= thr);
      if (!en) begin
         acc_next = '0;
         cnt_next = 4'h0;
      end else if (fire) begin
         acc_next = sum - thr;
         cnt_next = CF_PULSE_LD;
      end else begin
         acc_next = sum;
         cnt_next = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
      end
      out_next = (cnt_next != 4'h0);
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         acc_reg <= '0;
         cnt_reg <= 4'h0;
         out_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign pulse_out = out_reg;

   // Width of one pulse, active high, when not cut by disable
   sequence cf_high_run;
      pulse_out [*8] ##1 !pulse_out;
   endsequence

   AST_CF_PULSE_LEN: assert property (
      @(posedge mclk) disable iff (!nrst || !en)
      fire |=> cf_high_run)
      else $error("CF pulse width wrong");

endmodule : mfri_pulse_gen

// ### testbench/mfri_counter_model.sv
// Pulse counter model standing on the pulse outputs
`timescale 1ns/1ps
module mfri_counter_model (
   input  wire logic mclk,
   input  wire logic cf_in,
   input  wire logic lf_a,
   input  wire logic lf_b,
   output int        cf_cnt,
   output int        lf_seq
);
   logic q_cf = 1'b0;  // Previous levels, for edge detection
   logic q_a  = 1'b0;
   logic q_b  = 1'b0;
   // Count CF edges; stepper phases are logged as digits 1=a, 2=b
   initial begin
      cf_cnt = 0;
      lf_seq = 0;
   end
   always @(posedge mclk) begin
      if (cf_in && !q_cf)
         cf_cnt <= cf_cnt + 1;
      if (lf_a && !q_a)
         lf_seq <= lf_seq * 10 + 1;
      if (lf_b && !q_b)
         lf_seq <= lf_seq * 10 + 2;
      q_cf <= cf_in;
      q_a  <= lf_a;
      q_b  <= lf_b;
   end
endmodule : mfri_counter_model

// ### testbench/tb_meter_fault_reverse_indicator.sv
// Self-checking testbench of the fault and reverse-power block
`timescale 1ns/1ps
module tb_meter_fault_reverse_indicator import mfri_pkg::*;;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, meas_valid;
   logic supply_ok_pin, gain_select, freq_select_hi, freq_select_lo;
   logic cal_freq_select, fault_flag, reverse_power_flag, irq, e, rv_q;
   logic calibration_pulse_out, low_freq_out_a, low_freq_out_b, cf_q;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, q;
   logic [MIS_W-1:0]  missing_neutral_cal_in;
   mfri_meas_t        meas;
   int errors = 0, samples_checked = 0, cf_cnt, lf_seq, n0;
   mfri_core i_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .meas, .meas_valid,
      .missing_neutral_cal_in, .supply_ok_pin, .gain_select,
      .freq_select_hi, .freq_select_lo, .cal_freq_select, .fault_flag,
      .reverse_power_flag, .calibration_pulse_out, .low_freq_out_a,
      .low_freq_out_b, .irq);
   mfri_counter_model i_far (.mclk, .cf_in(calibration_pulse_out),
      .lf_a(low_freq_out_a), .lf_b(low_freq_out_b), .cf_cnt, .lf_seq);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      if (errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   // APB transfer: setup, then access until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50) begin
         errors++;
         give_verdict();
      end
   endtask : apb
   // Bounded wait for a level on a pulse output
   task automatic wait_on(ref logic s, input logic v);
      int n = 0;
      while (s !== v && n < 9000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 9000) begin
         errors++;
         give_verdict();
      end
   endtask : wait_on
   // The reverse flag may only move on a CF rising edge
   always @(posedge mclk) begin
      if (nrst === 1'b1 && reverse_power_flag !== rv_q)
         check(calibration_pulse_out & ~cf_q, 1);
      rv_q <= reverse_power_flag;
      cf_q <= calibration_pulse_out;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, meas_valid, nrst} = '0;
      {gain_select, freq_select_hi, freq_select_lo, cal_freq_select} = '0;
      {missing_neutral_cal_in, supply_ok_pin} = 9'h001;
      meas = '{16'h1000, 16'h1100, 16'h1000, 24'h0, 24'h0};
      cyc(16);
      nrst <= 1'b1;
      apb(0, REG_CTRL, 0);
      check(q, 1);
      check(pready, 1);
      apb(0, REG_IRQ_MASK, 0);
      check(q, 0);
      apb(0, 8'h40, 0);
      check(e, 1);
      check(fault_flag, 0);
      meas.current_in_b <= 16'h1200;
      cyc(3);
      check(fault_flag, 1);
      meas <= '{16'h1000, 16'h1000, 16'h0010, 24'h0, 24'h0};
      cyc(3);
      check(fault_flag, 1);
      // Power small enough that CF keeps up: no energy backlog builds
      meas <= '{16'h1000, 16'h1000, 16'h1000, 24'hF00000, 24'hF00000};
      cyc(3);
      check(fault_flag, 0);
      meas_valid <= 1'b1;
      wait_on(calibration_pulse_out, 1);
      check(reverse_power_flag, 1);
      meas.pwr_a <= 24'h100000;
      meas.pwr_b <= 24'h100000;
      repeat (2) begin
         wait_on(calibration_pulse_out, 0);
         wait_on(calibration_pulse_out, 1);
      end
      check(reverse_power_flag, 0);
      apb(1, REG_IRQ_MASK, 32'h1 << IRQ_CF);
      wait_on(calibration_pulse_out, 0);
      wait_on(calibration_pulse_out, 1);
      cyc(2);
      check(irq, 1);
      apb(1, REG_IRQ_MASK, 0);
      cyc(2);
      check(irq, 0);
      apb(1, REG_IRQ_STAT, 32'h1F);
      for (int n = 0; n < 9000 && lf_seq < 100; n++)
         cyc(1);
      check(lf_seq, 121);
      meas.volt_mag <= 16'h0010;
      cyc(60);
      n0 = cf_cnt;
      cyc(200);
      check(cf_cnt, n0);
      missing_neutral_cal_in <= 8'h80;
      wait_on(calibration_pulse_out, 1);
      // Let the counter model register the edge before reading it
      cyc(2);
      check(cf_cnt, n0 + 1);
      {gain_select, freq_select_hi, freq_select_lo, cal_freq_select} <= 4'hA;
      cyc(8);
      apb(0, REG_STATUS, 0);
      check(q[11:8], 4'hA);
      supply_ok_pin <= 1'b0;
      cyc(20);
      n0 = cf_cnt;
      cyc(300);
      check(cf_cnt, n0);
      check(low_freq_out_a | low_freq_out_b, 0);
      give_verdict();
   end
endmodule : tb_meter_fault_reverse_indicator
